// ---- hw/ssp_port.sv ----
`timescale 1ns/10ps
// Contract
// - SPI only when mode 01 and enabled
// - Master SCK divides fsys by 4 to 512
// - Bit order 0 sends MSB first
// - Interrupt when done flag and enable set
// - Unselected slave tristates MISO
// - Byte takes exactly eight SCK periods
// - Unselected slave ignores SCK
// - Shift in and out together
// - Data write loads tx, read returns rx
// - Master write starts transfer when idle
// - Write during transfer sets collision flag
// - Master end sets done flag, interrupt
// - Master done means received byte ready
// - Master select 0 gives slave mode
// - Slave sets done after eight bits
// - Slave holds rx while done is set
// - Slave sends 0x00 when nothing loaded
// - Collision flag sticky, no interrupt, no halt
// - Polarity bit sets idle SCK level
// - Phase 0 captures on first edge
// - Phase 1 drives first edge, captures second
module ssp_port (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Configuration
  input wire logic [1:0] SERIAL_MODE_SELECT,
  input wire logic PORT_ENABLE,
  input wire logic MASTER_SELECT,
  input wire logic CLOCK_IDLE_POLARITY,
  input wire logic CLOCK_SAMPLE_PHASE,
  input wire logic [2:0] SCK_DIVIDER_SELECT,
  input wire logic BIT_ORDER_SELECT,
  input wire logic BUFFER_IRQ_ENABLE,
  // Data register access
  input wire logic DATA_WR,
  input wire logic [7:0] DATA_WDATA,
  output logic [7:0] DATA_RDATA,
  // Status flags and their software clears
  input wire logic DONE_CLR,
  input wire logic COLLISION_CLR,
  output logic TRANSFER_DONE_FLAG,
  output logic WRITE_COLLISION_FLAG,
  output logic TX_BUSY,
  output logic SPI_IRQ,
  // Serial clock pin
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE_N,
  // Master-out data pin
  input wire logic MOSI_IN,
  output logic MOSI_OUT,
  output logic MOSI_OE_N,
  // Master-in data pin
  input wire logic MISO_IN,
  output logic MISO_OUT,
  output logic MISO_OE_N,
  // Slave select, active low
  input wire logic SS_N_IN
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ssp_pkg::ssp_state_t state_r, state_nxt;
  logic [ssp_pkg::SYNC_WIDTH-1:0] sync_q;
  logic [7:0] shift_r, rx_r;
  logic [3:0] edge_cnt_r;
  logic [8:0] div_cnt_r;
  logic [4:0] tgl_cnt_r;
  logic samp_r, sck_r, sck_d_r, done_r, coll_r;
  wire sck_s, mosi_s, miso_s, ss_n_s, active, is_master, m_run, slave_sel;
  wire half_tick, sck_edge, edge_ev, samp_edge, shift_edge, last_ev, shift_do;
  wire din, ins_bit, out_bit, busy, wr_ok, wr_coll, start;
  wire [8:0] half_lim;
  wire [7:0] shifted;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  // SCK enters relative to idle and SS inverted: the flops' reset zero
  // means idle and deselected, so no false edge or select after reset
  ssp_sync #(.WIDTH(ssp_pkg::SYNC_WIDTH)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d_in({SCK_IN ^ CLOCK_IDLE_POLARITY, MOSI_IN, MISO_IN, !SS_N_IN}),
    .q_out(sync_q)
  );

  assign {sck_s, mosi_s, miso_s, ss_n_s} = sync_q ^ 4'h1;

  // ----------------------------------------------------------------
  // Mode decode and event selection
  // ----------------------------------------------------------------
  // SPI mode gate
  assign active = (SERIAL_MODE_SELECT == ssp_pkg::MODE_SPI) && PORT_ENABLE;
  assign is_master = active && MASTER_SELECT;
  assign m_run = is_master && (state_r == ssp_pkg::SSP_RUN);
  assign slave_sel = active && !MASTER_SELECT && !ss_n_s;
  // half period is 2 << select
  assign half_lim = (ssp_pkg::HALF_BASE << SCK_DIVIDER_SELECT) - 9'h001;
  assign half_tick = (div_cnt_r == half_lim);
  assign sck_edge = sck_s ^ sck_d_r;
  // slave takes nothing while done is set
  assign edge_ev = m_run ? half_tick : (slave_sel && sck_edge && !done_r);
  // phase 0 samples on even edges
  // phase 1 samples on odd edges
  assign samp_edge = edge_ev && (edge_cnt_r[0] == CLOCK_SAMPLE_PHASE);
  assign shift_edge = edge_ev && !samp_edge &&
                      !(CLOCK_SAMPLE_PHASE && (edge_cnt_r == 4'h0));
  assign last_ev = edge_ev && (edge_cnt_r == ssp_pkg::LAST_EDGE);
  assign shift_do = shift_edge || (last_ev && CLOCK_SAMPLE_PHASE);

  // ----------------------------------------------------------------
  // Shift datapath
  // ----------------------------------------------------------------
  // one register shifts out and in at once
  assign din = is_master ? miso_s : mosi_s;
  assign ins_bit = (last_ev && CLOCK_SAMPLE_PHASE) ? din : samp_r;
  assign shifted = BIT_ORDER_SELECT ? {ins_bit, shift_r[7:1]}
                                    : {shift_r[6:0], ins_bit};
  assign out_bit = BIT_ORDER_SELECT ? shift_r[0] : shift_r[7];

  // Data register writes, refused when a byte is in flight
  assign busy = m_run || (!MASTER_SELECT && (edge_cnt_r != 4'h0));
  assign wr_ok = DATA_WR && active && !busy;
  assign wr_coll = DATA_WR && active && busy;
  assign start = wr_ok && MASTER_SELECT;

  // write loads transmit, read returns receive
  // refill with zero after each byte
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_r <= ssp_pkg::DATA_RST;
    end else if (wr_ok) begin
      shift_r <= DATA_WDATA;
    end else if (last_ev) begin
      shift_r <= ssp_pkg::IDLE_FILL;
    end else if (shift_do) begin
      shift_r <= shifted;
    end
  end

  // received byte lands with the done flag
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_r <= ssp_pkg::DATA_RST;
    end else if (last_ev) begin
      rx_r <= shifted;
    end
  end

  // Sampled bit waits for the following shift edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      samp_r <= 1'b0;
    end else if (samp_edge) begin
      samp_r <= din;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      edge_cnt_r <= 4'h0;
    end else if (!active || (!MASTER_SELECT && ss_n_s) || start) begin
      edge_cnt_r <= 4'h0;
    end else if (edge_ev) begin
      edge_cnt_r <= edge_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Master sequencer and clock generator
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ssp_pkg::SSP_IDLE: begin
        if (start) begin
          state_nxt = ssp_pkg::SSP_RUN;
        end
      end
      ssp_pkg::SSP_RUN: begin
        if (last_ev || !is_master) begin
          state_nxt = ssp_pkg::SSP_IDLE;
        end
      end
      default: begin
        state_nxt = ssp_pkg::SSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ssp_pkg::SSP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // divider restarts at every half period
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt_r <= 9'h000;
    end else if (!m_run || half_tick) begin
      div_cnt_r <= 9'h000;
    end else begin
      div_cnt_r <= div_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_r <= 1'b0;
    end else if (!m_run) begin
      sck_r <= CLOCK_IDLE_POLARITY;
    end else if (half_tick) begin
      sck_r <= ~sck_r;
    end
  end

  // Edge detector reads only the synchronised copy
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // done set at byte end, set beats clear
  // slave sets done after eight bits
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_r <= ssp_pkg::FLAG_RST;
    end else if (last_ev) begin
      done_r <= 1'b1;
    end else if (DONE_CLR) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      coll_r <= ssp_pkg::FLAG_RST;
    end else if (wr_coll) begin
      coll_r <= 1'b1;
    end else if (COLLISION_CLR) begin
      coll_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign DATA_RDATA = rx_r;
  assign TRANSFER_DONE_FLAG = done_r;
  assign WRITE_COLLISION_FLAG = coll_r;
  assign TX_BUSY = busy;
  // interrupt needs done and enable; collision never feeds it
  assign SPI_IRQ = done_r && BUFFER_IRQ_ENABLE;
  assign SCK_OUT = sck_r;
  assign SCK_OE_N = !is_master;
  assign MOSI_OUT = out_bit;
  assign MOSI_OE_N = !is_master;
  assign MISO_OUT = out_bit;
  assign MISO_OE_N = !slave_sel;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Counts SCK toggles within one master byte
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tgl_cnt_r <= 5'h00;
    end else if (start) begin
      tgl_cnt_r <= 5'h00;
    end else if (m_run && half_tick) begin
      tgl_cnt_r <= tgl_cnt_r + 5'h01;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence seq_wr_idle;
    DATA_WR && is_master && (state_r == ssp_pkg::SSP_IDLE);
  endsequence
  sequence seq_running;
    (state_r == ssp_pkg::SSP_RUN) && (edge_cnt_r == 4'h0);
  endsequence
  AST_IRQ_ON_DONE: assert property (
    $rose(done_r) && BUFFER_IRQ_ENABLE |-> SPI_IRQ)
    else $error("Done flag set without interrupt");
  AST_MISO_RELEASE: assert property (
    !MASTER_SELECT && ss_n_s |-> MISO_OE_N)
    else $error("Unselected slave drives MISO");
  AST_EIGHT_PERIODS: assert property (
    last_ev && m_run |-> tgl_cnt_r == ssp_pkg::EDGES_BEFORE_LAST
    ##1 SCK_OUT == CLOCK_IDLE_POLARITY)
    else $error("Master byte not sixteen clock edges");
  AST_SLAVE_IGNORE: assert property (
    active && !MASTER_SELECT && ss_n_s |=> edge_cnt_r == 4'h0)
    else $error("Unselected slave counts edges");
  AST_MASTER_START: assert property (
    seq_wr_idle |=> seq_running ##0 shift_r == $past(DATA_WDATA))
    else $error("Idle master write did not start");
  AST_COLLISION: assert property (
    DATA_WR && active && busy && !last_ev |=> coll_r && $stable(state_r))
    else $error("Collision not flagged or transfer disturbed");
  AST_DONE_STICKY: assert property (
    done_r && !DONE_CLR |=> done_r)
    else $error("Done flag dropped without clear");
  AST_COLL_STICKY: assert property (
    coll_r && !COLLISION_CLR |=> coll_r)
    else $error("Collision flag dropped without clear");
  AST_RX_HOLD: assert property (
    !MASTER_SELECT && done_r && !DONE_CLR |=> $stable(rx_r))
    else $error("Slave receive changed while done set");
  AST_ZERO_FILL: assert property (
    last_ev |=> shift_r == ssp_pkg::IDLE_FILL)
    else $error("Transmit not refilled with zero");
endmodule : ssp_port

// ---- shared/ssp_pkg.sv ----
package ssp_pkg;
  // ----------------------------------------------------------------
  // Mode, framing and reset constants
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SPI = 2'h1;    // Serial mode code for SPI
  localparam logic [3:0] LAST_EDGE = 4'hf;   // 16 edges = 8 SCK periods
  localparam logic [4:0] EDGES_BEFORE_LAST = 5'h0f;
  localparam logic [8:0] HALF_BASE = 9'h002; // Half period at fsys/4
  localparam logic [7:0] IDLE_FILL = 8'h00;  // Sent when nothing loaded
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam int SYNC_WIDTH = 4;

  // Master sequencer states
  typedef enum logic [0:0] {
    SSP_IDLE = 1'b0,
    SSP_RUN = 1'b1
  } ssp_state_t;
endpackage : ssp_pkg

// ---- hw/ssp_sync.sv ----
`timescale 1ns/10ps
// Two-flop synchroniser for pins that arrive from outside CLK's domain
module ssp_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous inputs and their synchronised copies
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;

  // Only the second stage is visible to the rest of the design
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule : ssp_sync

// ---- verification/ssp_far_end.sv ----
`timescale 1ns/10ps
// ------
// Far-end slave model, MSB first, reacts at once to SCK
// ------
module ssp_far_end (
  // Pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  // Mode and data
  input wire logic clock_sample_phase,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  int n;
  initial miso = 1'b0;
  // load on select, first bit early in phase 0
  always @(negedge ss_n) begin
    sh = tx_byte;
    n = 0;
    // Phase 1 shows its first bit only at the first edge
    miso = clock_sample_phase ? ~tx_byte[7] : tx_byte[7];
    if (!clock_sample_phase) sh = sh << 1;
  end
  // Released line shows the inverse, so a stale bit never passes
  always @(posedge ss_n) miso = ~miso;
  always @(sck) begin
    if (!ss_n) begin
      if (n[0] == clock_sample_phase) rx_byte = {rx_byte[6:0], mosi};
      else begin
        miso = sh[7];
        sh = sh << 1;
      end
      n = n + 1;
    end
  end
endmodule : ssp_far_end

// ---- verification/ssp_port_tb.sv ----
`timescale 1ns/10ps
// ------
// Bench for the serial port, master and slave
// ------
module ssp_port_tb;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, mst = 1'b1, wr = 1'b0;
  logic clock_idle_polarity = 1'b0, clock_sample_phase = 1'b0, bo = 1'b0, irq_en = 1'b0;
  logic done_clr = 1'b0, coll_clr = 1'b0, tb_sck = 1'b0;
  logic tb_mosi = 1'b0, tb_ss_n = 1'b1, far_ss_n = 1'b1;
  logic [1:0] mode = 2'h1;
  logic [2:0] div = 3'h0;
  logic [7:0] wr_data = 8'h00, far_tx = 8'h00;
  logic [7:0] rdata, far_rx;
  logic done, coll, busy, irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n;
  logic miso_o, miso_oe_n, far_miso;
  wire sck_w = sck_oe_n ? tb_sck : sck_o;
  wire mosi_w = mosi_oe_n ? tb_mosi : mosi_o;
  // Wire delay stands for the far end's hold margin: in phase 1 the
  // port refills MOSI on the CLK edge that makes the last sample edge
  wire #2 far_mosi = mosi_w;
  wire miso_w = miso_oe_n ? far_miso : miso_o;
  int mismatches = 0, checks = 0, edges = 0;

  always #50 clk = ~clk;
  // Count link edges only while the far end is selected
  always @(sck_w) if (!far_ss_n) edges++;

  ssp_port uut (.CLK(clk), .RST_N(rst_n), .SERIAL_MODE_SELECT(mode),
    .PORT_ENABLE(en), .MASTER_SELECT(mst), .CLOCK_IDLE_POLARITY(clock_idle_polarity),
    .CLOCK_SAMPLE_PHASE(clock_sample_phase), .SCK_DIVIDER_SELECT(div),
    .BIT_ORDER_SELECT(bo), .BUFFER_IRQ_ENABLE(irq_en), .DATA_WR(wr),
    .DATA_WDATA(wr_data), .DATA_RDATA(rdata), .DONE_CLR(done_clr),
    .COLLISION_CLR(coll_clr), .TRANSFER_DONE_FLAG(done),
    .WRITE_COLLISION_FLAG(coll), .TX_BUSY(busy), .SPI_IRQ(irq),
    .SCK_IN(sck_w), .SCK_OUT(sck_o), .SCK_OE_N(sck_oe_n),
    .MOSI_IN(mosi_w), .MOSI_OUT(mosi_o), .MOSI_OE_N(mosi_oe_n),
    .MISO_IN(miso_w), .MISO_OUT(miso_o), .MISO_OE_N(miso_oe_n),
    .SS_N_IN(tb_ss_n));

  ssp_far_end far (.sck(sck_w), .mosi(far_mosi), .ss_n(far_ss_n),
    .miso(far_miso), .clock_sample_phase(clock_sample_phase), .tx_byte(far_tx), .rx_byte(far_rx));

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  task check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // Inputs always move 1 ns after the rising edge
  task step;
    @(posedge clk);
    #1;
  endtask : step

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction : rev

  task automatic mxfer(input logic [7:0] tx, input logic [7:0] ft,
                       input logic [2:0] sel, input logic col);
    int cnt;
    div = sel;
    far_tx = ft;
    edges = 0;
    far_ss_n = 1'b0;
    wr_data = tx;
    wr = 1'b1;
    step;
    wr = 1'b0;
    cnt = 0;
    while (done !== 1'b1 && cnt < 5000) begin
      step;
      cnt++;
      wr = col && cnt == 5;
      wr_data = ~tx;
      if (cnt == 3) check(busy, 1);
      if (cnt == 3) check({sck_oe_n, mosi_oe_n}, 0);
    end
    if (cnt >= 5000) begin
      mismatches++;
      end_of_test;
    end
    check(16'(cnt), 16'(16 * (2 << sel)));
    repeat (20) step;
    check(done, 1);
    check(16'(edges), 16);
    check(rdata, bo ? rev(ft) : ft);
    check(far_rx, bo ? rev(tx) : tx);
    check(sck_w, clock_idle_polarity);
    check(irq, irq_en);
    check(coll, col);
    far_ss_n = 1'b1;
    done_clr = 1'b1;
    coll_clr = 1'b1;
    step;
    done_clr = 1'b0;
    coll_clr = 1'b0;
    step;
    check({done, coll}, 0);
  endtask : mxfer

  // Testbench plays master on the link at 800 ns per SCK period
  task automatic sxfer(input logic [7:0] tx, input logic ss,
                       input logic chk, input logic [7:0] em);
    logic [7:0] sh, got;
    sh = tx;
    got = 8'h00;
    tb_ss_n = ss;
    repeat (4) step;
    check(miso_oe_n, ss);
    if (!clock_sample_phase) begin
      tb_mosi = sh[7];
      sh = sh << 1;
    end
    repeat (4) step;
    for (int e = 0; e < 16; e++) begin
      if (e[0] == clock_sample_phase) got = {got[6:0], miso_w};
      tb_sck = ~tb_sck;
      if (e[0] != clock_sample_phase) begin
        tb_mosi = sh[7];
        sh = sh << 1;
      end
      repeat (4) step;
    end
    repeat (4) step;
    tb_ss_n = 1'b1;
    step;
    if (chk) check(got, em);
  endtask : sxfer

  initial begin
    repeat (16) step;
    rst_n = 1'b1;
    step;
    for (int k = 0; k < 2; k++) begin
      {mode, en} = k ? 3'b010 : 3'b101;
      wr_data = 8'h5a;
      wr = 1'b1;
      step;
      wr = 1'b0;
      repeat (8) step;
      check({busy, sck_oe_n, mosi_oe_n, coll}, 4'b0110);
    end
    $display("inactive port test done");
    {mode, en} = 3'b011;
    for (int m = 0; m < 4; m++) begin
      {clock_idle_polarity, clock_sample_phase} = 2'(m);
      bo = m[0];
      irq_en = m[1];
      repeat (4) step;
      mxfer(8'h96 ^ 8'(m), 8'hc3 ^ 8'(m), (m == 3) ? 3'h7 : 3'(m + 1),
            m == 1);
      $display("master test %0d done", m);
    end
    {mst, clock_idle_polarity, clock_sample_phase, bo, irq_en} = 5'b00001;
    repeat (4) step;
    sxfer(8'h77, 1'b1, 1'b0, 8'h00);
    check(done, 0);
    wr_data = 8'ha5;
    wr = 1'b1;
    step;
    wr = 1'b0;
    sxfer(8'h3c, 1'b0, 1'b1, 8'ha5);
    check({done, irq, rdata}, 16'h033c);
    sxfer(8'h81, 1'b0, 1'b0, 8'h00);
    check({done, rdata}, 16'h013c);
    done_clr = 1'b1;
    step;
    done_clr = 1'b0;
    clock_sample_phase = 1'b1;
    repeat (4) step;
    sxfer(8'h42, 1'b0, 1'b1, 8'h00);
    check({done, rdata}, 16'h0142);
    $display("slave tests done");
    end_of_test;
  end
endmodule : ssp_port_tb
